// file: src/i2c_slave_rx.sv
// Two-wire slave receiver end-of-transfer and bus error unit, AXI4-Lite slave
// Behaviour
// - General call data NACKed reports 0x98, flag
// - Clear with start 0, ack 0: ignore addresses
// - Clear with ack 1: own address still recognised
// - General call recognised only with enable bit set
// - Clear with start 1: START once bus free
// - STOP/restart while addressed reports 0xA0, flag
// - Flag clear means status reads 0xF8
// - Misplaced START/STOP in frame reports 0x00
// - Bus error sets the step-done flag
// - Recovery: not addressed, stop request cleared, rest kept
// - Recovery releases both lines, sends no STOP
// - Status code in upper five bits, prescaler low
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_rx_defs.svh"
module i2c_slave_rx (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Open-drain bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt
  output logic irq
);
  // Bus slave state
  logic awready_r, awready_nxt, wready_r, wready_nxt, aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0] awaddr_r, awaddr_nxt, w_byte_r, w_byte_nxt;
  logic w_lane_r, w_lane_nxt, bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [7:0] rdata_r, rdata_nxt, rd_byte;
  logic rd_ok;
  // Software-controlled registers
  logic ack_en_r, ack_en_nxt, sta_r, sta_nxt, sto_r, sto_nxt, en_r, en_nxt, gce_r, gce_nxt;
  logic [6:0] own_addr_r, own_addr_nxt;
  logic [1:0] pre_r, pre_nxt;
  // Write strobes
  logic do_wr, wr_ctrl, clr_flag, irq_clr_wr, irq_en_wr;
  // Link state
  i2c_rx_pkg::link_state_type state_r, state_nxt, resume_r, resume_nxt;
  logic [3:0] bitcnt_r, bitcnt_nxt;
  logic [7:0] shift_r, shift_nxt, code_r, code_nxt, data_r, data_nxt, stat_vis;
  logic [9:0] cnt_r, cnt_nxt;
  logic flag_r, flag_set, ack_sel_r, ack_sel_nxt, gc_r, gc_nxt, hold_r, hold_nxt;
  logic sda_oe_r, sda_oe_nxt, scl_oe_r, scl_oe_nxt, busy_r, busy_nxt, pend_r, pend_nxt;
  logic ev_start, berr, sto_clr, own_hit, gc_hit;
  // Pins and interrupt
  logic [1:0] pins_s;
  logic scl_p_r, sda_p_r, scl_rise, scl_fall, start_c, stop_c, line_lvl_r;
  logic [`EV_W-1:0] ev, irq_status, irq_enable;

  sync_2ff #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({scl_in, sda_in}),
    .q(pins_s)
  );

  // Line events, judged only on synchronised levels
  assign scl_rise = pins_s[1] & ~scl_p_r;
  assign scl_fall = ~pins_s[1] & scl_p_r;
  assign start_c = pins_s[1] & scl_p_r & sda_p_r & ~pins_s[0];
  assign stop_c = pins_s[1] & scl_p_r & ~sda_p_r & pins_s[0];

  // Address recognition needs acknowledge enable; general call also its own enable
  assign own_hit = ack_en_r && shift_r == {own_addr_r, 1'b0};
  assign gc_hit = ack_en_r && gce_r && shift_r == 8'h00;
  assign stat_vis = flag_r ? code_r : `ST_NONE;

  // Write decode
  assign do_wr = aw_got_r & w_got_r & ~bvalid_r;
  assign wr_ctrl = do_wr && w_lane_r && awaddr_r == `OFF_CTRL;
  assign clr_flag = wr_ctrl && w_byte_r[`CTL_FLAG];
  assign irq_clr_wr = do_wr && w_lane_r && awaddr_r == `OFF_IRQ_CLR;
  assign irq_en_wr = do_wr && w_lane_r && awaddr_r == `OFF_IRQ_EN;

  // Link sequencer: frame tracking, acknowledge, stretching, START/STOP issue
  always_comb begin
    state_nxt = state_r;
    resume_nxt = resume_r;
    bitcnt_nxt = bitcnt_r;
    shift_nxt = shift_r;
    code_nxt = code_r;
    data_nxt = data_r;
    cnt_nxt = cnt_r;
    ack_sel_nxt = ack_sel_r;
    gc_nxt = gc_r;
    hold_nxt = hold_r;
    sda_oe_nxt = sda_oe_r;
    scl_oe_nxt = scl_oe_r;
    pend_nxt = pend_r;
    flag_set = 1'b0;
    berr = 1'b0;
    ev_start = 1'b0;
    sto_clr = 1'b0;
    busy_nxt = start_c ? 1'b1 : (stop_c ? 1'b0 : busy_r);
    case (state_r)
      i2c_rx_pkg::st_idle: begin
        if (start_c) begin
          state_nxt = i2c_rx_pkg::st_addr;
          bitcnt_nxt = 4'h0;
        end else if (pend_r && !busy_r && en_r) begin
          state_nxt = i2c_rx_pkg::st_start_gen;
          sda_oe_nxt = 1'b1;
          cnt_nxt = 10'h000;
          pend_nxt = 1'b0;
        end
      end
      i2c_rx_pkg::st_addr, i2c_rx_pkg::st_data: begin
        // A STOP or restart shows its SCL rise first, so one counted bit is still the frame edge
        if ((start_c || stop_c) && bitcnt_r > 4'h1) begin
          berr = 1'b1;
        end else if (stop_c && state_r == i2c_rx_pkg::st_addr) begin
          state_nxt = i2c_rx_pkg::st_idle;
        end else if (start_c && state_r == i2c_rx_pkg::st_addr) begin
          bitcnt_nxt = 4'h0;
        end else if ((start_c || stop_c) && state_r == i2c_rx_pkg::st_data) begin
          code_nxt = `ST_STOP_RX;
          flag_set = 1'b1;
          resume_nxt = i2c_rx_pkg::st_idle;
          state_nxt = i2c_rx_pkg::st_wait;
        end else if (scl_rise) begin
          shift_nxt = {shift_r[6:0], pins_s[0]};
          bitcnt_nxt = bitcnt_r + 4'h1;
        end else if (scl_fall && bitcnt_r == 4'h8) begin
          if (state_r == i2c_rx_pkg::st_data) begin
            sda_oe_nxt = ack_sel_r;
            state_nxt = i2c_rx_pkg::st_data_ack;
          end else if (own_hit || gc_hit) begin
            sda_oe_nxt = 1'b1;
            gc_nxt = gc_hit & ~own_hit;
            state_nxt = i2c_rx_pkg::st_addr_ack;
          end else begin
            state_nxt = i2c_rx_pkg::st_idle;
          end
        end
      end
      i2c_rx_pkg::st_addr_ack, i2c_rx_pkg::st_data_ack: begin
        if (start_c || stop_c) begin
          berr = 1'b1;
        end else if (scl_rise) begin
          bitcnt_nxt = 4'h9;
        end else if (scl_fall && bitcnt_r == 4'h9) begin
          sda_oe_nxt = 1'b0;
          flag_set = 1'b1;
          hold_nxt = 1'b1;
          scl_oe_nxt = 1'b1;
          state_nxt = i2c_rx_pkg::st_wait;
          if (state_r == i2c_rx_pkg::st_addr_ack) begin
            code_nxt = gc_r ? `ST_GC : `ST_SLA_W;
            resume_nxt = i2c_rx_pkg::st_data;
          end else begin
            data_nxt = shift_r;
            resume_nxt = ack_sel_r ? i2c_rx_pkg::st_data : i2c_rx_pkg::st_idle;
            if (gc_r) begin
              code_nxt = ack_sel_r ? `ST_GC_DATA_ACK : `ST_GC_DATA_NACK;
            end else begin
              code_nxt = ack_sel_r ? `ST_DATA_ACK : `ST_DATA_NACK;
            end
          end
        end
      end
      i2c_rx_pkg::st_wait: begin
        // Release on clear; the byte just written chooses the next mode
        if (clr_flag) begin
          hold_nxt = 1'b0;
          scl_oe_nxt = 1'b0;
          bitcnt_nxt = 4'h0;
          ack_sel_nxt = w_byte_r[`CTL_ACK];
          state_nxt = resume_r;
          if (code_r == `ST_BUS_ERR) begin
            state_nxt = i2c_rx_pkg::st_idle;
            sto_clr = w_byte_r[`CTL_STO];
          end else if (resume_r == i2c_rx_pkg::st_idle) begin
            pend_nxt = w_byte_r[`CTL_STA];
          end
        end
      end
      i2c_rx_pkg::st_start_gen: begin
        cnt_nxt = cnt_r + 10'h001;
        if (cnt_r == 10'(`START_HOLD_CYC - 1)) begin
          scl_oe_nxt = 1'b1;
          ev_start = 1'b1;
          state_nxt = i2c_rx_pkg::st_own;
        end
      end
      i2c_rx_pkg::st_own: begin
        // Bus held after our START until software asks for a STOP
        if (sto_r) begin
          scl_oe_nxt = 1'b0;
          cnt_nxt = 10'h000;
          state_nxt = i2c_rx_pkg::st_stop_gen;
        end
      end
      i2c_rx_pkg::st_stop_gen: begin
        cnt_nxt = cnt_r + 10'h001;
        if (cnt_r == 10'(`START_HOLD_CYC - 1)) begin
          sda_oe_nxt = 1'b0;
          sto_clr = 1'b1;
          state_nxt = i2c_rx_pkg::st_idle;
        end
      end
      default: begin
        state_nxt = i2c_rx_pkg::st_idle;
      end
    endcase
    // Bus error: flag, code 0x00, lines let go without any STOP
    if (berr) begin
      code_nxt = `ST_BUS_ERR;
      flag_set = 1'b1;
      sda_oe_nxt = 1'b0;
      scl_oe_nxt = 1'b0;
      hold_nxt = 1'b0;
      resume_nxt = i2c_rx_pkg::st_idle;
      state_nxt = i2c_rx_pkg::st_wait;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= i2c_rx_pkg::st_idle;
      resume_r <= i2c_rx_pkg::st_idle;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      code_r <= `ST_NONE;
      data_r <= 8'h00;
      cnt_r <= 10'h000;
      flag_r <= 1'b0;
      ack_sel_r <= 1'b0;
      gc_r <= 1'b0;
      hold_r <= 1'b0;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
      busy_r <= 1'b0;
      pend_r <= 1'b0;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      line_lvl_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      resume_r <= resume_nxt;
      bitcnt_r <= bitcnt_nxt;
      shift_r <= shift_nxt;
      code_r <= code_nxt;
      data_r <= data_nxt;
      cnt_r <= cnt_nxt;
      flag_r <= flag_set | (flag_r & ~clr_flag); // Set beats clear
      ack_sel_r <= ack_sel_nxt;
      gc_r <= gc_nxt;
      hold_r <= hold_nxt;
      sda_oe_r <= sda_oe_nxt;
      scl_oe_r <= scl_oe_nxt;
      busy_r <= busy_nxt;
      pend_r <= pend_nxt;
      scl_p_r <= pins_s[1];
      sda_p_r <= pins_s[0];
      line_lvl_r <= 1'b0; // Open drain only ever pulls low
    end
  end

  // Bus slave: one-cycle ready pulses, write done when address and data are both in
  always_comb begin
    awready_nxt = awvalid & ~awready_r & ~aw_got_r & ~bvalid_r;
    wready_nxt = wvalid & ~wready_r & ~w_got_r & ~bvalid_r;
    aw_got_nxt = (aw_got_r | (awvalid & awready_r)) & ~do_wr;
    w_got_nxt = (w_got_r | (wvalid & wready_r)) & ~do_wr;
    awaddr_nxt = (awvalid & awready_r) ? awaddr : awaddr_r;
    w_byte_nxt = (wvalid & wready_r) ? wdata[7:0] : w_byte_r;
    w_lane_nxt = (wvalid & wready_r) ? wstrb[0] : w_lane_r;
    bvalid_nxt = do_wr | (bvalid_r & ~bready);
    bresp_nxt = bresp_r;
    ack_en_nxt = ack_en_r;
    sta_nxt = sta_r;
    sto_nxt = sto_r;
    en_nxt = en_r;
    own_addr_nxt = own_addr_r;
    gce_nxt = gce_r;
    pre_nxt = pre_r;
    if (do_wr) begin
      bresp_nxt = (awaddr_r <= `OFF_IRQ_EN && awaddr_r[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
      if (wr_ctrl) begin
        ack_en_nxt = w_byte_r[`CTL_ACK];
        sta_nxt = w_byte_r[`CTL_STA];
        sto_nxt = w_byte_r[`CTL_STO];
        en_nxt = w_byte_r[`CTL_EN];
      end
      if (w_lane_r && awaddr_r == `OFF_STAT) begin
        pre_nxt = w_byte_r[1:0];
      end
      if (w_lane_r && awaddr_r == `OFF_ADDR) begin
        own_addr_nxt = w_byte_r[7:1];
        gce_nxt = w_byte_r[`ADR_GCE];
      end
    end
    // Hardware clear of the stop request wins over the write that set it
    if (sto_clr) begin
      sto_nxt = 1'b0;
    end
    arready_nxt = arvalid & ~arready_r & ~rvalid_r;
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    case (araddr)
      `OFF_CTRL: begin
        rd_byte[`CTL_FLAG] = flag_r;
        rd_byte[`CTL_ACK] = ack_en_r;
        rd_byte[`CTL_STA] = sta_r;
        rd_byte[`CTL_STO] = sto_r;
        rd_byte[`CTL_EN] = en_r;
      end
      `OFF_STAT: rd_byte = {stat_vis[7:3], 1'b0, pre_r};
      `OFF_DATA: rd_byte = data_r;
      `OFF_ADDR: rd_byte = {own_addr_r, gce_r};
      `OFF_IRQ_STAT: rd_byte = {5'h00, irq_status};
      `OFF_IRQ_CLR: rd_byte = 8'h00;
      `OFF_IRQ_EN: rd_byte = {5'h00, irq_enable};
      default: rd_ok = 1'b0;
    endcase
    rvalid_nxt = (arvalid & arready_r) | (rvalid_r & ~rready);
    rdata_nxt = (arvalid & arready_r) ? rd_byte : rdata_r;
    rresp_nxt = (arvalid & arready_r) ? (rd_ok ? `RESP_OKAY : `RESP_SLVERR) : rresp_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      w_byte_r <= 8'h00;
      w_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
      rresp_r <= `RESP_OKAY;
      ack_en_r <= 1'b0;
      sta_r <= 1'b0;
      sto_r <= 1'b0;
      en_r <= 1'b0;
      own_addr_r <= 7'h00;
      gce_r <= 1'b0;
      pre_r <= 2'h0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      w_byte_r <= w_byte_nxt;
      w_lane_r <= w_lane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ack_en_r <= ack_en_nxt;
      sta_r <= sta_nxt;
      sto_r <= sto_nxt;
      en_r <= en_nxt;
      own_addr_r <= own_addr_nxt;
      gce_r <= gce_nxt;
      pre_r <= pre_nxt;
    end
  end

  // Events: every flag set, bus errors, our own START
  assign ev = {ev_start, berr, flag_set};

  irq_block #(.W(`EV_W)) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev(ev),
    .clr_wr(irq_clr_wr),
    .en_wr(irq_en_wr),
    .wr_data(w_byte_r[`EV_W-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );

  // Outputs
  assign awready = awready_r;
  assign wready = wready_r;
  assign bresp = bresp_r;
  assign bvalid = bvalid_r;
  assign arready = arready_r;
  assign rdata = {24'h000000, rdata_r};
  assign rresp = rresp_r;
  assign rvalid = rvalid_r;
  assign scl_out = line_lvl_r;
  assign sda_out = line_lvl_r;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_byte_end;
    scl_fall && bitcnt_r == 4'h8 && state_r == i2c_rx_pkg::st_addr;
  endsequence
  sequence s_gc_nack_end;
    state_r == i2c_rx_pkg::st_data_ack && gc_r && !ack_sel_r && scl_fall && bitcnt_r == 4'h9;
  endsequence

  property p_gc_nack;
    s_gc_nack_end |=> flag_r && code_r == `ST_GC_DATA_NACK && scl_oe_r;
  endproperty
  a_gc_nack: assert property (p_gc_nack) else $error("no 0x98 after gc nack");
  property p_ack_off;
    s_byte_end and !ack_en_r |=> state_r == i2c_rx_pkg::st_idle && !sda_oe_r;
  endproperty
  a_ack_off: assert property (p_ack_off) else $error("address acked with ack off");
  property p_own_hit;
    s_byte_end and ack_en_r && shift_r == {own_addr_r, 1'b0} |=> sda_oe_r [*2];
  endproperty
  a_own_hit: assert property (p_own_hit) else $error("own address not acked");
  property p_gc_gate;
    s_byte_end and shift_r == 8'h00 && !gce_r && own_addr_r != 7'h00
      |=> state_r == i2c_rx_pkg::st_idle;
  endproperty
  a_gc_gate: assert property (p_gc_gate) else $error("gc acked while disabled");
  property p_start_req;
    state_r == i2c_rx_pkg::st_idle && pend_r && !busy_r && en_r && !start_c
      |=> sda_oe_r && !scl_oe_r;
  endproperty
  a_start_req: assert property (p_start_req) else $error("no START on free bus");
  property p_stop_rx;
    state_r == i2c_rx_pkg::st_data && bitcnt_r <= 4'h1 && stop_c
      |=> flag_r && code_r == `ST_STOP_RX;
  endproperty
  a_stop_rx: assert property (p_stop_rx) else $error("no 0xA0 on stop");
  property p_stat_read;
    arvalid && arready_r && araddr == `OFF_STAT && !flag_r
      |=> rvalid_r && rdata_r == (`ST_NONE | {6'h00, $past(pre_r)});
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("bad idle status read");
  property p_berr;
    (state_r == i2c_rx_pkg::st_data || state_r == i2c_rx_pkg::st_addr) && bitcnt_r > 4'h1
      && (start_c || stop_c) |=> flag_r && code_r == `ST_BUS_ERR ##1 flag_r || $past(clr_flag);
  endproperty
  a_berr: assert property (p_berr) else $error("bus error not flagged");
  property p_recover;
    state_r == i2c_rx_pkg::st_wait && clr_flag && code_r == `ST_BUS_ERR && w_byte_r[`CTL_STO]
      |=> state_r == i2c_rx_pkg::st_idle && !sto_r && ack_en_r == $past(w_byte_r[`CTL_ACK]);
  endproperty
  a_recover: assert property (p_recover) else $error("bad bus error recovery");
  property p_release;
    flag_r && code_r == `ST_BUS_ERR |-> !sda_oe_r && !scl_oe_r;
  endproperty
  a_release: assert property (p_release) else $error("line driven in bus error");
  property p_stretch;
    state_r == i2c_rx_pkg::st_wait && hold_r && !clr_flag |=> scl_oe_r && flag_r;
  endproperty
  a_stretch: assert property (p_stretch) else $error("SCL not stretched");
endmodule
`default_nettype wire

// file: src/i2c_rx_defs.svh
// Constants for the two-wire slave receiver: offsets, bits, codes, timing
`ifndef I2C_RX_DEFS_SVH
`define I2C_RX_DEFS_SVH

// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_DATA 8'h08
`define OFF_ADDR 8'h0C
`define OFF_IRQ_STAT 8'h10
`define OFF_IRQ_CLR 8'h14
`define OFF_IRQ_EN 8'h18

// Control register bit positions
`define CTL_FLAG 7
`define CTL_ACK 6
`define CTL_STA 5
`define CTL_STO 4
`define CTL_EN 2

// Address register: general call enable bit, address in bits 7:1
`define ADR_GCE 0

// Interrupt event bits
`define EV_FLAG 0
`define EV_BERR 1
`define EV_START 2
`define EV_W 3

// Status codes, prescaler bits taken as zero
`define ST_SLA_W 8'h60
`define ST_GC 8'h70
`define ST_DATA_ACK 8'h80
`define ST_DATA_NACK 8'h88
`define ST_GC_DATA_ACK 8'h90
`define ST_GC_DATA_NACK 8'h98
`define ST_STOP_RX 8'hA0
`define ST_NONE 8'hF8
`define ST_BUS_ERR 8'h00

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing: clock period and START/STOP hold time on the bus
`define CLK_PERIOD_PS 5000
`define START_HOLD_NS 4000
`define START_HOLD_CYC ((`START_HOLD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// file: src/i2c_rx_pkg.sv
// Types shared by the two-wire slave receiver
package i2c_rx_pkg;
  typedef enum logic [3:0] {
    st_idle, st_addr, st_addr_ack, st_data, st_data_ack, st_wait,
    st_start_gen, st_own, st_stop_gen
  } link_state_type;
endpackage

// file: src/sync_2ff.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous inputs and synchronised outputs
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // Resets high, matching idle pulled-up lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= {W{1'b1}};
      q_r <= {W{1'b1}};
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule
`default_nettype wire

// file: src/irq_block.sv
// Sticky event status, write-one clear, enable mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module irq_block #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Event pulses
  input wire logic [W-1:0] ev,
  // Register writes
  input wire logic clr_wr,
  input wire logic en_wr,
  input wire logic [W-1:0] wr_data,
  // Register state and interrupt
  output logic [W-1:0] status,
  output logic [W-1:0] enable,
  output logic irq
);
  logic [W-1:0] status_r, status_nxt;
  logic [W-1:0] enable_r, enable_nxt;
  logic irq_r, irq_nxt;

  // A new event beats a clear in the same cycle
  always_comb begin
    status_nxt = status_r;
    if (clr_wr) begin
      status_nxt = status_r & ~wr_data;
    end
    status_nxt = status_nxt | ev;
    enable_nxt = en_wr ? wr_data : enable_r;
    irq_nxt = |(status_nxt & enable_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
      enable_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      enable_r <= enable_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign status = status_r;
  assign enable = enable_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// file: dv/i2c_master_model.sv
// Remote two-wire bus master: open-drain SCL and SDA, 160 ns per bit
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  // Resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // Pull-low enables
  output logic scl_oe,
  output logic sda_oe
);
  localparam time HALF = 80;
  // Both lines released so the pull-ups hold them high; SCL stands still between frames
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // SDA falls while SCL is high; also serves as a repeated START
  task automatic start_c;
    sda_oe = 1'b0;
    #HALF scl_oe = 1'b0;
    wait (scl);
    #HALF sda_oe = 1'b1;
    #HALF scl_oe = 1'b1;
    #HALF;
  endtask
  // SDA rises while SCL is high
  task automatic stop_c;
    sda_oe = 1'b1;
    #HALF scl_oe = 1'b0;
    wait (scl);
    #HALF sda_oe = 1'b0;
    #HALF;
  endtask
  // Data changes only while SCL is low; the rise waits out any stretching
  task automatic bit_c(input logic b, output logic r);
    sda_oe = !b;
    #(HALF / 2) scl_oe = 1'b0;
    wait (scl);
    #HALF r = sda;
    scl_oe = 1'b1;
    #(HALF / 2);
  endtask
  // Eight bits first-high, then the acknowledge slot with SDA released
  task automatic byte_c(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], r);
    end
    bit_c(1'b1, r);
    ack = !r;
  endtask
endmodule
`default_nettype wire

// file: dv/i2c_slave_rx_tb.sv
// Self-checking bench for the slave receiver end and bus error unit
`timescale 1ns/1ps
`default_nettype none
`include "i2c_rx_defs.svh"
module i2c_slave_rx_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, scl_oe, sda_oe, irq, m_scl_oe, m_sda_oe, ack, r;
  logic [7:0] awaddr, araddr, d;
  logic [6:0] own;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, ps, resp;
  int err_count, total_checks, seed;
  // Open-drain lines with pull-ups
  wire scl = !(scl_oe | m_scl_oe);
  wire sda = !(sda_oe | m_sda_oe);
  i2c_slave_rx u_i2c_slave_rx (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .irq(irq));
  i2c_master_model u_i2c_master_model (.scl(scl), .sda(sda), .scl_oe(m_scl_oe),
    .sda_oe(m_sda_oe));
  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Status word as software sees it: code on top, prescaler below
  function automatic logic [31:0] st(input logic [7:0] c);
    return {24'h000000, c[7:3], 1'b0, ps};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    @(posedge aclk);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected few tens of microseconds
  initial begin
    #200000;
    err_count++;
    end_sim;
  end
  // Main sequence
  initial begin
    seed = 85375;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    ps = 2'($random(seed));
    own = {1'b1, 6'($random(seed))};
    d = 8'($random(seed));
    wr(`OFF_STAT, {30'h0, ps});
    rd(`OFF_STAT);
    chk("status", v, st(`ST_NONE));
    rd(8'h20);
    chk("unmapped", 32'(resp), 32'(`RESP_SLVERR));
    wr(8'h20, 32'h00000000);
    chk("wr unmapped", 32'(resp), 32'(`RESP_SLVERR));
    wr(`OFF_ADDR, {24'h0, own, 1'b1});
    wr(`OFF_IRQ_EN, 32'h00000001);
    wr(`OFF_CTRL, 32'h00000044);
    u_i2c_master_model.start_c;
    u_i2c_master_model.byte_c(8'h00, ack);
    chk("gc ack", 32'(ack), 32'h1);
    rd(`OFF_STAT);
    chk("status", v, st(`ST_GC));
    chk("irq", 32'(irq), 32'h1);
    wr(`OFF_IRQ_CLR, 32'h00000001);
    rd(`OFF_IRQ_STAT);
    chk("irq", 32'(irq), 32'h0);
    // Clear choosing NACK for the data byte
    wr(`OFF_CTRL, 32'h00000084);
    u_i2c_master_model.byte_c(d, ack);
    chk("nack", 32'(ack), 32'h0);
    rd(`OFF_STAT);
    chk("status", v, st(`ST_GC_DATA_NACK));
    rd(`OFF_DATA);
    chk("data", v, 32'(d));
    wr(`OFF_CTRL, 32'h000000C4);
    u_i2c_master_model.stop_c;
    u_i2c_master_model.start_c;
    u_i2c_master_model.byte_c({own, 1'b0}, ack);
    chk("own ack", 32'(ack), 32'h1);
    rd(`OFF_STAT);
    chk("status", v, st(`ST_SLA_W));
    chk("stretch", 32'(scl_oe), 32'h1);
    wr(`OFF_CTRL, 32'h000000C4);
    d = 8'($random(seed));
    u_i2c_master_model.byte_c(d, ack);
    chk("data ack", 32'(ack), 32'h1);
    rd(`OFF_DATA);
    chk("data", v, 32'(d));
    wr(`OFF_CTRL, 32'h000000C4);
    u_i2c_master_model.stop_c;
    rd(`OFF_STAT);
    chk("status", v, st(`ST_STOP_RX));
    // Clear with start 0 and ack 0: own address must now be ignored
    wr(`OFF_CTRL, 32'h00000084);
    u_i2c_master_model.start_c;
    u_i2c_master_model.byte_c({own, 1'b0}, ack);
    chk("ignored", 32'(ack), 32'h0);
    u_i2c_master_model.stop_c;
    rd(`OFF_STAT);
    chk("status", v, st(`ST_NONE));
    // STOP three bits into an address byte
    u_i2c_master_model.start_c;
    repeat (3) u_i2c_master_model.bit_c(1'($random(seed)), r);
    u_i2c_master_model.stop_c;
    rd(`OFF_STAT);
    chk("status", v, st(`ST_BUS_ERR));
    rd(`OFF_CTRL);
    chk("control", v, 32'h00000084);
    chk("lines", {30'h0, scl_oe, sda_oe}, 32'h0);
    wr(`OFF_CTRL, 32'h00000094);
    rd(`OFF_CTRL);
    chk("control", v, 32'h00000004);
    chk("lines", {30'h0, scl_oe, sda_oe}, 32'h0);
    rd(`OFF_STAT);
    chk("status", v, st(`ST_NONE));
    // Gc with its enable off is ignored; later our own START once the bus is free
    wr(`OFF_ADDR, {24'h0, own, 1'b0});
    wr(`OFF_CTRL, 32'h00000044);
    u_i2c_master_model.start_c;
    u_i2c_master_model.byte_c(8'h00, ack);
    chk("gc off", 32'(ack), 32'h0);
    u_i2c_master_model.start_c;
    u_i2c_master_model.byte_c({own, 1'b0}, ack);
    wr(`OFF_CTRL, 32'h000000C4);
    u_i2c_master_model.stop_c;
    wr(`OFF_CTRL, 32'h000000A4);
    repeat (900) @(posedge aclk);
    chk("own start", {30'h0, scl, sda}, 32'h0);
    rd(`OFF_IRQ_STAT);
    chk("irq stat", v, 32'h00000007);
    wr(`OFF_CTRL, 32'h00000094);
    repeat (900) @(posedge aclk);
    chk("released", {30'h0, scl, sda}, 32'h3);
    rd(`OFF_CTRL);
    chk("control", v, 32'h00000004);
    end_sim;
  end
endmodule
`default_nettype wire
